/* qec_counter.sv */
// Functional notes
// - Single, double and quadruple edge count modes per encoder.
// - Count up when lead phase leads, down when it lags.
// - Index marker edge zeroes the position counter when enabled.
// - Count is 16 bits (low word) or 32 bits with a high word.
// - Lead phase on an even channel, quadrature phase on the next odd one.
// - Two encoders without index; only one encoder when index is used.
// - Each input debounced, sixteen times from 500 ns to 25.5 ms.
// - All counters start at zero at the start of an acquisition.
// - Phase transitions up to 20 MHz are counted without loss.
// - Debounce accepts after stable, before stable, or bypass.
// - Optional input inversion ahead of debounce, with or without debounce.
`timescale 1ns/1ps
`include "qec_map.svh"
module qec_counter
  import qec_pkg::*;
#(
  parameter int P_CHANNELS = 4,
  parameter int P_DB_MAX_CYC = `QEC_DB_MAX_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Acquisition timing
  input wire logic i_acq_start,
  input wire logic i_scan_start,
  // Counter input pins
  input wire logic [P_CHANNELS-1:0] i_cnt_in,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Live positions
  output logic [31:0] o_pos0,
  output logic [31:0] o_pos1
);

  localparam int CW = `QEC_DB_CNT_W;

  // Debounce time lookup, clipped so simulation can shorten long settings
  function automatic logic [CW-1:0] db_cycles(input logic [3:0] sel);
    int unsigned t;
    case (sel)
      4'h0: t = `QEC_NS_TO_CYC(`QEC_DB_T0_NS);
      4'h1: t = `QEC_NS_TO_CYC(`QEC_DB_T1_NS);
      4'h2: t = `QEC_NS_TO_CYC(`QEC_DB_T2_NS);
      4'h3: t = `QEC_NS_TO_CYC(`QEC_DB_T3_NS);
      4'h4: t = `QEC_NS_TO_CYC(`QEC_DB_T4_NS);
      4'h5: t = `QEC_NS_TO_CYC(`QEC_DB_T5_NS);
      4'h6: t = `QEC_NS_TO_CYC(`QEC_DB_T6_NS);
      4'h7: t = `QEC_NS_TO_CYC(`QEC_DB_T7_NS);
      4'h8: t = `QEC_NS_TO_CYC(`QEC_DB_T8_NS);
      4'h9: t = `QEC_NS_TO_CYC(`QEC_DB_T9_NS);
      4'ha: t = `QEC_NS_TO_CYC(`QEC_DB_T10_NS);
      4'hb: t = `QEC_NS_TO_CYC(`QEC_DB_T11_NS);
      4'hc: t = `QEC_NS_TO_CYC(`QEC_DB_T12_NS);
      4'hd: t = `QEC_NS_TO_CYC(`QEC_DB_T13_NS);
      4'he: t = `QEC_NS_TO_CYC(`QEC_DB_T14_NS);
      default: t = `QEC_NS_TO_CYC(`QEC_DB_T15_NS);
    endcase
    if (t > P_DB_MAX_CYC) begin
      t = P_DB_MAX_CYC;
    end
    db_cycles = CW'(t);
  endfunction

  // Step for one encoder: count flag and direction; a double change gives no count
  function automatic logic [1:0] quad_step(input qec_phase_t prev, input qec_phase_t cur,
                                           input qec_count_mode_t mode);
    logic a_chg;
    logic b_chg;
    logic up;
    logic hit;
    a_chg = prev.lead ^ cur.lead;
    b_chg = prev.quad ^ cur.quad;
    up = 1'b0;
    hit = 1'b0;
    // Lead edge: up if new lead differs from quad; quad edge: up if equal
    if (a_chg && !b_chg) begin
      up = cur.lead ^ cur.quad;
      case (mode)
        QEC_SINGLE_EDGE_COUNT_MODE: hit = cur.lead;
        QEC_DOUBLE_EDGE_COUNT_MODE: hit = 1'b1;
        QEC_QUAD_EDGE_COUNT_MODE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end else if (b_chg && !a_chg) begin
      up = ~(cur.lead ^ cur.quad);
      hit = (mode == QEC_QUAD_EDGE_COUNT_MODE);
    end
    quad_step = {hit, up};
  endfunction

  // Control and config registers
  logic [31:0] ctrl_r;
  logic [31:0] dbcfg_r;
  logic [P_CHANNELS-1:0] sync1_r;
  logic [P_CHANNELS-1:0] sync2_r;
  logic [P_CHANNELS-1:0] filt;
  qec_phase_t prev0_r;
  qec_phase_t prev1_r;
  logic idx_prev_r;
  logic [31:0] cnt0_r;
  logic [31:0] cnt1_r;
  logic [31:0] lat0_r;
  logic [31:0] lat1_r;
  logic [1:0] dir_r;
  logic [1:0] err_r;
  logic [1:0] step0;
  logic [1:0] step1;
  logic err0;
  logic err1;
  logic idx_en;
  logic en0;
  logic en1;
  logic idx_hit;

  // Software writes to control
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_r <= `QEC_CTRL_RST;
    end else if (i_wr && i_addr == `QEC_REG_CTRL) begin
      ctrl_r <= i_wdata;
    end
  end

  // Software writes to debounce configuration
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      dbcfg_r <= `QEC_DBCFG_RST;
    end else if (i_wr && i_addr == `QEC_REG_DBCFG) begin
      dbcfg_r <= i_wdata;
    end
  end

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_cnt_in;
      sync2_r <= sync1_r;
    end
  end

  // Inversion then debounce on every channel
  genvar g;
  generate
    for (g = 0; g < P_CHANNELS; g++) begin : g_ch
      qec_db_cfg_t cfg;
      assign cfg = qec_db_cfg_t'(dbcfg_r[g*`QEC_DB_BYTE_W +: 7]);
      qec_debounce #(
        .P_CNT_W(CW)
      ) u_db (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_mode(cfg.mode),
        .i_cyc(db_cycles(cfg.tsel)),
        .i_din(sync2_r[g] ^ cfg.inv),
        .o_dout(filt[g])
      );
    end
  endgenerate

  // Encoder 1 uses channels 2 and 3 unless channel 2 carries the index
  assign idx_en = ctrl_r[`QEC_CTRL_IDX_EN];
  assign en0 = ctrl_r[`QEC_CTRL_EN0];
  assign en1 = ctrl_r[`QEC_CTRL_EN1] && !idx_en;
  assign idx_hit = idx_en && en0 && filt[2] && !idx_prev_r;

  // Even channel is the lead phase, next odd the quadrature phase
  assign step0 = quad_step(prev0_r, '{lead: filt[0], quad: filt[1]},
                           qec_count_mode_t'(ctrl_r[`QEC_CTRL_MODE0_LSB +: 2]));
  assign step1 = quad_step(prev1_r, '{lead: filt[2], quad: filt[3]},
                           qec_count_mode_t'(ctrl_r[`QEC_CTRL_MODE1_LSB +: 2]));
  assign err0 = (prev0_r.lead ^ filt[0]) && (prev0_r.quad ^ filt[1]);
  assign err1 = (prev1_r.lead ^ filt[2]) && (prev1_r.quad ^ filt[3]);

  // Phase and index history, one sample per clock so 20 MHz edges are seen
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      prev0_r <= '0;
      prev1_r <= '0;
      idx_prev_r <= 1'b0;
    end else begin
      prev0_r <= '{lead: filt[0], quad: filt[1]};
      prev1_r <= '{lead: filt[2], quad: filt[3]};
      idx_prev_r <= filt[2];
    end
  end

  // Encoder 0 position; 16-bit mode keeps the high word at zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_acq_start) begin
      cnt0_r <= '0;
    end else if (idx_hit) begin
      cnt0_r <= '0;
    end else if (en0 && step0[1]) begin
      if (ctrl_r[`QEC_CTRL_WIDE0]) begin
        cnt0_r <= step0[0] ? cnt0_r + 32'h1 : cnt0_r - 32'h1;
      end else begin
        cnt0_r <= {16'h0, step0[0] ? cnt0_r[15:0] + 16'h1 : cnt0_r[15:0] - 16'h1};
      end
    end
  end

  // Encoder 1 position
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_acq_start) begin
      cnt1_r <= '0;
    end else if (en1 && step1[1]) begin
      if (ctrl_r[`QEC_CTRL_WIDE1]) begin
        cnt1_r <= step1[0] ? cnt1_r + 32'h1 : cnt1_r - 32'h1;
      end else begin
        cnt1_r <= {16'h0, step1[0] ? cnt1_r[15:0] + 16'h1 : cnt1_r[15:0] - 16'h1};
      end
    end
  end

  // Scan start latches the counts for reading
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_acq_start) begin
      lat0_r <= '0;
      lat1_r <= '0;
    end else if (i_scan_start) begin
      lat0_r <= cnt0_r;
      lat1_r <= cnt1_r;
    end
  end

  // Last direction seen per encoder
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      dir_r <= '0;
    end else begin
      if (en0 && step0[1]) begin
        dir_r[0] <= step0[0];
      end
      if (en1 && step1[1]) begin
        dir_r[1] <= step1[0];
      end
    end
  end

  // Sticky invalid-transition flags, write one to clear; a new event wins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      err_r <= '0;
    end else begin
      if (i_wr && i_addr == `QEC_REG_STATUS) begin
        err_r <= (err_r & ~i_wdata[`QEC_ST_ERR_LSB +: 2]) | {err1 && en1, err0 && en0};
      end else begin
        err_r <= err_r | {err1 && en1, err0 && en0};
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        `QEC_REG_CTRL: o_rdata <= ctrl_r;
        `QEC_REG_DBCFG: o_rdata <= dbcfg_r;
        `QEC_REG_ENC0_LO: o_rdata <= {16'h0, lat0_r[15:0]};
        `QEC_REG_ENC0_HI: o_rdata <= {16'h0, lat0_r[31:16]};
        `QEC_REG_ENC1_LO: o_rdata <= {16'h0, lat1_r[15:0]};
        `QEC_REG_ENC1_HI: o_rdata <= {16'h0, lat1_r[31:16]};
        `QEC_REG_STATUS: o_rdata <= {24'h0, err_r, dir_r, filt};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  assign o_pos0 = cnt0_r;
  assign o_pos1 = cnt1_r;

endmodule

/* qec_map.svh */
`ifndef QEC_MAP_SVH
`define QEC_MAP_SVH

// Register word offsets on the plain register port
`define QEC_REG_CTRL 4'h0
`define QEC_REG_DBCFG 4'h1
`define QEC_REG_ENC0_LO 4'h2
`define QEC_REG_ENC0_HI 4'h3
`define QEC_REG_ENC1_LO 4'h4
`define QEC_REG_ENC1_HI 4'h5
`define QEC_REG_STATUS 4'h6

// Reset values
`define QEC_CTRL_RST 32'h0000_0000
`define QEC_DBCFG_RST 32'h0000_0000

// Control register fields
`define QEC_CTRL_EN0 0
`define QEC_CTRL_EN1 1
`define QEC_CTRL_MODE0_LSB 2
`define QEC_CTRL_MODE1_LSB 4
`define QEC_CTRL_IDX_EN 6
`define QEC_CTRL_WIDE0 7
`define QEC_CTRL_WIDE1 8

// Debounce config: one byte per input channel
`define QEC_DB_MODE_LSB 0
`define QEC_DB_INV_BIT 2
`define QEC_DB_TSEL_LSB 4
`define QEC_DB_BYTE_W 8

// Status register fields
`define QEC_ST_LEVEL_LSB 0
`define QEC_ST_DIR_LSB 4
`define QEC_ST_ERR_LSB 6

// Clock and debounce times
`define QEC_CLK_MHZ 100
`define QEC_DB_T0_NS 500
`define QEC_DB_T1_NS 1000
`define QEC_DB_T2_NS 2000
`define QEC_DB_T3_NS 5000
`define QEC_DB_T4_NS 10000
`define QEC_DB_T5_NS 20000
`define QEC_DB_T6_NS 50000
`define QEC_DB_T7_NS 100000
`define QEC_DB_T8_NS 200000
`define QEC_DB_T9_NS 500000
`define QEC_DB_T10_NS 1000000
`define QEC_DB_T11_NS 2000000
`define QEC_DB_T12_NS 5000000
`define QEC_DB_T13_NS 10000000
`define QEC_DB_T14_NS 20000000
`define QEC_DB_T15_NS 25500000
`define QEC_NS_TO_CYC(t) (((t) * `QEC_CLK_MHZ) / 1000)
`define QEC_DB_MAX_CYC `QEC_NS_TO_CYC(`QEC_DB_T15_NS)
`define QEC_DB_CNT_W 22

`endif

/* qec_pkg.sv */
package qec_pkg;

  // Edge counting modes
  typedef enum logic [1:0] {
    QEC_SINGLE_EDGE_COUNT_MODE = 2'h0,
    QEC_DOUBLE_EDGE_COUNT_MODE = 2'h1,
    QEC_QUAD_EDGE_COUNT_MODE = 2'h2
  } qec_count_mode_t;

  // Debounce modes
  typedef enum logic [1:0] {
    QEC_DB_BYPASS = 2'h0,
    QEC_DB_AFTER_STABLE = 2'h1,
    QEC_DB_BEFORE_STABLE = 2'h2
  } qec_db_mode_t;

  // Per-channel input conditioning settings
  typedef struct packed {
    logic [3:0] tsel;
    logic inv;
    qec_db_mode_t mode;
  } qec_db_cfg_t;

  // One phase pair sample
  typedef struct packed {
    logic lead;
    logic quad;
  } qec_phase_t;

endpackage

/* qec_debounce.sv */
`timescale 1ns/1ps
module qec_debounce
  import qec_pkg::*;
#(
  parameter int P_CNT_W = 22
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Settings
  input wire qec_db_mode_t i_mode,
  input wire logic [P_CNT_W-1:0] i_cyc,
  // Conditioned level in, filtered level out
  input wire logic i_din,
  output logic o_dout
);

  logic last_r;
  logic [P_CNT_W-1:0] stable_r;
  logic stable_ok;

  // The count saturates, so a long quiet input never wraps into a false unstable state
  assign stable_ok = (stable_r >= i_cyc);

  // Previous sample
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      last_r <= 1'b0;
    end else begin
      last_r <= i_din;
    end
  end

  // Cycles the input has held its level
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stable_r <= '0;
    end else if (i_din != last_r) begin
      stable_r <= '0;
    end else if (!stable_ok) begin
      stable_r <= stable_r + 1'b1;
    end
  end

  // Output level per mode
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_dout <= 1'b0;
    end else begin
      case (i_mode)
        QEC_DB_BYPASS: o_dout <= i_din;
        QEC_DB_AFTER_STABLE: begin
          if (i_din == last_r && stable_ok) begin
            o_dout <= i_din;
          end
        end
        QEC_DB_BEFORE_STABLE: begin
          // Edge passes at once if the prior level was quiet long enough
          if (i_din != o_dout && stable_ok) begin
            o_dout <= i_din;
          end
        end
        default: o_dout <= i_din;
      endcase
    end
  end

endmodule

/* qec_counter_chk.sv */
`timescale 1ns/1ps
`include "qec_map.svh"
module qec_counter_chk
  import qec_pkg::*;
#(
  parameter int P_CHANNELS = 4,
  parameter int P_DB_MAX_CYC = 40
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Watched inputs
  input wire logic i_acq_start,
  input wire logic [P_CHANNELS-1:0] i_cnt_in,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  // Watched outputs
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_pos0,
  input wire logic [31:0] o_pos1
);
  logic [31:0] ctrl_r;
  logic [23:0] quiet_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Shadow of the control word, so checks know which counts may move
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_r <= 32'h0;
    end else if (i_wr && i_addr == `QEC_REG_CTRL) begin
      ctrl_r <= i_wdata;
    end
  end
  // Quiet time on the pins; any write restarts it, as inversion moves filters
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_wr || i_cnt_in != $past(i_cnt_in)) begin
      quiet_r <= 24'h0;
    end else if (quiet_r != 24'hff_ffff) begin
      quiet_r <= quiet_r + 24'h1;
    end
  end
  rd_idle_zero_a: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data outside a read answer");
  unmapped_rd_a: assert property (i_rd && i_addr > `QEC_REG_STATUS |=> o_rdata == 32'h0)
    else $error("unmapped read gave data");
  acq_clear_a: assert property (i_acq_start |=> o_pos0 == 32'h0 && o_pos1 == 32'h0)
    else $error("acquisition start left a count");
  single_step_a: assert property (o_pos0 == 32'h0 ||
    16'(o_pos0 - $past(o_pos0)) inside {16'h0, 16'h1, 16'hffff})
    else $error("count moved by more than one");
  narrow_high_a: assert property (!ctrl_r[`QEC_CTRL_WIDE0] &&
    !$past(ctrl_r[`QEC_CTRL_WIDE0]) |-> o_pos0[31:16] == 16'h0)
    else $error("narrow count has a high word");
  index_hold_a: assert property (ctrl_r[`QEC_CTRL_IDX_EN] &&
    $past(ctrl_r[`QEC_CTRL_IDX_EN]) && !$past(i_acq_start) |-> $stable(o_pos1))
    else $error("second encoder counted with index in use");
  off_hold_a: assert property (!ctrl_r[`QEC_CTRL_EN0] &&
    !$past(ctrl_r[`QEC_CTRL_EN0]) && !$past(i_acq_start) |-> $stable(o_pos0))
    else $error("disabled encoder counted");
  quiet_hold_a: assert property (quiet_r > P_DB_MAX_CYC + 16 &&
    !$past(i_acq_start) |-> $stable(o_pos0) && $stable(o_pos1))
    else $error("count moved with quiet pins");
  idx_cov_c: cover property (ctrl_r[`QEC_CTRL_IDX_EN] && o_pos0 != $past(o_pos0));
  acq_cov_c: cover property (i_acq_start ##1 o_pos0 == 32'h0);
  rd_cov_c: cover property (i_rd ##1 o_rdata != 32'h0);
endmodule

/* qec_enc_model.sv */
`timescale 1ns/1ps
module qec_enc_model
  import qec_pkg::*;
(
  // Paces the shaft only; a real encoder is free running
  input wire logic i_clk,
  // Phase pair onto two counter pins
  output qec_phase_t o_phase
);
  int st = 0;
  initial o_phase = 2'b00;
  // Gray order: turning forward, lead rises while quad is low
  function automatic qec_phase_t code(input int s);
    code.lead = (s == 1) || (s == 2);
    code.quad = (s >= 2);
  endfunction
  // Legal travel, one phase at a time
  task automatic move(input int n, input bit up, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge i_clk);
      st = up ? (st + 1) % 4 : (st + 3) % 4;
      o_phase <= code(st);
    end
  endtask
  // Fault on command only: both phases flip together
  task automatic jump(input int gap);
    repeat (gap) @(posedge i_clk);
    st = (st + 2) % 4;
    o_phase <= code(st);
  endtask
endmodule

/* test_quadrature_encoder_counter.sv */
`timescale 1ns/1ps
`include "qec_map.svh"
`define CHK(nm, e, g) checked++; \
  if ((g) !== (e)) begin \
    $display("unexpected %s expected %h seen %h", nm, e, g); \
    num_errors++; \
  end
module test_quadrature_encoder_counter;
  import qec_pkg::*;
  localparam int DBC = 40;
  logic i_clk, i_resetn, i_acq_start, i_scan_start, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_pos0, o_pos1, e0, e1, d, msk;
  qec_phase_t ph0, ph1;
  int num_errors, checked, seed, n0, n1;
  bit up0, up1;
  // Lead phase on the even pin, quadrature phase on the next odd one
  wire logic [3:0] pins = {ph1.quad, ph1.lead, ph0.quad, ph0.lead};
  qec_counter #(.P_CHANNELS(4), .P_DB_MAX_CYC(DBC)) i_qec_counter (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_acq_start(i_acq_start),
    .i_scan_start(i_scan_start), .i_cnt_in(pins), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pos0(o_pos0), .o_pos1(o_pos1));
  qec_enc_model i_qec_enc_model0 (.i_clk(i_clk), .o_phase(ph0));
  qec_enc_model i_qec_enc_model1 (.i_clk(i_clk), .o_phase(ph1));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Expected travel: counted edges per mode, signed by direction
  function automatic logic [31:0] delta(input int s, input int n, input bit up, input int m);
    logic [31:0] r;
    bit a0;
    bit a1;
    r = 32'h0;
    for (int k = 0; k < n; k++) begin
      a0 = (s == 1) || (s == 2);
      s = up ? (s + 1) % 4 : (s + 3) % 4;
      a1 = (s == 1) || (s == 2);
      if (m == 2 || (m == 1 && a0 != a1) || (m == 0 && a1 && !a0)) begin
        r = up ? r + 32'h1 : r - 32'h1;
      end
    end
    return r;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic pulse(input bit scan);
    @(posedge i_clk);
    i_scan_start <= scan;
    i_acq_start <= !scan;
    @(posedge i_clk);
    i_scan_start <= 1'b0;
    i_acq_start <= 1'b0;
  endtask
  task automatic wait_pos(input logic [31:0] a, input logic [31:0] b, input int lim);
    for (int k = 0; k < lim && (o_pos0 !== a || o_pos1 !== b); k++) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    seed = 80879;
    num_errors = 0;
    checked = 0;
    i_resetn = 1'b0;
    {i_acq_start, i_scan_start, i_wr, i_rd} = 4'h0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    // Reset values, then a refused write and read at an unmapped word
    rd(`QEC_REG_CTRL);
    `CHK("ctrl", `QEC_CTRL_RST, d)
    rd(`QEC_REG_DBCFG);
    `CHK("dbcfg", `QEC_DBCFG_RST, d)
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf);
    `CHK("unmapped", 32'h0, d)
    $display("done reset");
    // Every mode on both encoders, random travel; encoder 0 at full pin rate, encoder 1 at a third of it
    for (int m = 0; m < 4; m++) begin
      pulse(0);
      wr(`QEC_REG_CTRL, 32'h3 | (m << 2) | (m << 4) | ((m & 1) << 7) | ((m & 1) << 8));
      n0 = 1 + {$random(seed)} % 12;
      n1 = 1 + {$random(seed)} % 12;
      up0 = (m != 0) && ($random(seed) & 1);
      up1 = $random(seed) & 1;
      msk = (m & 1) ? 32'hffff_ffff : 32'h0000_ffff;
      e0 = delta(i_qec_enc_model0.st, n0, up0, m) & msk;
      e1 = delta(i_qec_enc_model1.st, n1, up1, m) & msk;
      fork
        i_qec_enc_model0.move(n0, up0, 1);
        i_qec_enc_model1.move(n1, up1, 3);
      join
      wait_pos(e0, e1, 20);
      `CHK("pos0", e0, o_pos0)
      `CHK("pos1", e1, o_pos1)
      // Latch once before any read so a reference value exists
      pulse(1);
      rd(`QEC_REG_ENC0_LO);
      `CHK("lo0", e0[15:0], d[15:0])
      rd(`QEC_REG_ENC0_HI);
      `CHK("hi0", e0[31:16], d[15:0])
      rd(`QEC_REG_ENC1_LO);
      `CHK("lo1", e1[15:0], d[15:0])
      $display("done mode %0d", m);
    end
    // Index on pin 2 zeroes encoder 0 and keeps encoder 1 out of play
    pulse(0);
    wr(`QEC_REG_CTRL, 32'hcb);
    while (i_qec_enc_model1.st != 0) begin
      i_qec_enc_model1.move(1, 1, 3);
    end
    i_qec_enc_model0.move(5, 1, 2);
    wait_pos(32'h5, 32'h0, 20);
    i_qec_enc_model1.move(1, 1, 3);
    wait_pos(32'h0, 32'h0, 20);
    `CHK("index", 32'h0, o_pos0)
    i_qec_enc_model0.move(3, 1, 2);
    wait_pos(32'h3, 32'h0, 20);
    `CHK("after index", 32'h3, o_pos0)
    `CHK("pos1", 32'h0, o_pos1)
    $display("done index");
    // Inverting the lead pin turns forward travel into counting down
    wr(`QEC_REG_CTRL, 32'h89);
    wr(`QEC_REG_DBCFG, 32'h4);
    repeat (8) @(posedge i_clk);
    pulse(0);
    i_qec_enc_model0.move(3, 1, 2);
    wait_pos(32'hffff_fffd, 32'h0, 20);
    `CHK("inverted", 32'hffff_fffd, o_pos0)
    // After-stable: a short pulse is lost, a settled step waits out the time
    wr(`QEC_REG_DBCFG, 32'h0101);
    repeat (2 * DBC) @(posedge i_clk);
    pulse(0);
    i_qec_enc_model0.move(1, 1, 2);
    i_qec_enc_model0.move(1, 0, 10);
    repeat (2 * DBC) @(posedge i_clk);
    #1;
    `CHK("glitch", 32'h0, o_pos0)
    i_qec_enc_model0.move(1, 1, 2);
    repeat (DBC - 8) @(posedge i_clk);
    #1;
    `CHK("early", 32'h0, o_pos0)
    wait_pos(32'h1, 32'h0, 30);
    `CHK("settled", 32'h1, o_pos0)
    // Before-stable: a step after a quiet spell shows at once
    wr(`QEC_REG_DBCFG, 32'h0202);
    repeat (2 * DBC) @(posedge i_clk);
    pulse(0);
    i_qec_enc_model0.move(1, 1, DBC + 10);
    wait_pos(32'h1, 32'h0, 6);
    `CHK("prompt", 32'h1, o_pos0)
    $display("done filters");
    // Both phases flipping together is refused and flagged
    wr(`QEC_REG_DBCFG, 32'h0);
    repeat (8) @(posedge i_clk);
    pulse(0);
    i_qec_enc_model0.jump(3);
    repeat (8) @(posedge i_clk);
    #1;
    `CHK("both", 32'h0, o_pos0)
    rd(`QEC_REG_STATUS);
    `CHK("err", 1'b1, d[`QEC_ST_ERR_LSB])
    wr(`QEC_REG_STATUS, 32'hc0);
    rd(`QEC_REG_STATUS);
    `CHK("err clear", 2'h0, d[7:6])
    // Acquisition start clears the latched words too
    i_qec_enc_model0.move(2, 1, 2);
    wait_pos(32'h2, 32'h0, 20);
    rd(`QEC_REG_STATUS);
    `CHK("dir", 1'b1, d[`QEC_ST_DIR_LSB])
    pulse(1);
    pulse(0);
    rd(`QEC_REG_ENC0_LO);
    `CHK("latched", 32'h0, d)
    $display("done faults");
    end_of_test();
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    end_of_test();
  end
endmodule
bind qec_counter qec_counter_chk #(
  .P_CHANNELS(P_CHANNELS),
  .P_DB_MAX_CYC(P_DB_MAX_CYC)
) i_qec_counter_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_acq_start(i_acq_start), .i_cnt_in(i_cnt_in),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_pos0(o_pos0), .o_pos1(o_pos1)
);
